//--- include/deskew_pkg.sv
package deskew_pkg;

  // ==========================================================================
  // Register offsets in the host bus configuration space
  localparam logic [7:0] OFS_ADDR_IN_SUB23  = 8'ha8;
  localparam logic [7:0] OFS_MODE_CTL       = 8'ha9;
  localparam logic [7:0] OFS_STROBE_OUT_01  = 8'haa;
  localparam logic [7:0] OFS_STROBE_OUT_23  = 8'hab;
  localparam logic [7:0] OFS_DATA0_OUT_SUB01 = 8'hac;

  // ==========================================================================
  // Field positions of the mode control register
  localparam int MODE_LSB      = 0;
  localparam int THR_LSB       = 2;
  localparam int LOOPBACK_BIT  = 4;

  // ==========================================================================
  // Values after reset
  localparam logic [3:0] DELAY_FIELD_RST = 4'h7;
  localparam logic [1:0] MODE_RST        = 2'h3;
  localparam logic [1:0] THR_RST         = 2'h1;
  localparam logic       LOOPBACK_RST    = 1'b0;

  // ==========================================================================
  // Delay codes and threshold decode
  localparam logic [3:0] STROBE_FIXED_CODE = 4'h4;
  localparam logic [3:0] DELAY_CODE_MAX    = 4'hf;
  localparam logic [3:0] DELAY_CODE_MIN    = 4'h0;
  localparam logic [2:0] THR_ZERO_COUNT    = 3'h3;

  // ==========================================================================
  // Bit positions inside the second quadword of the strap ROM
  localparam int STRAP_LOOPBACK_BIT = 56;
  localparam int STRAP_THR_LSB      = 6;
  localparam int STRAP_MODE_LSB     = 4;
  localparam int STRAP_ADDR_IN_LSB  = 28;
  localparam int STRAP_STROBE_LSB   = 40;
  localparam int STRAP_DATA0_LSB    = 48;

  // ==========================================================================
  // Path lanes handled by the offset selector
  localparam int LANE_ADDR_SUB2  = 0;
  localparam int LANE_ADDR_SUB3  = 1;
  localparam int LANE_DATA0_SUB0 = 2;
  localparam int LANE_DATA0_SUB1 = 3;
  localparam int NUM_LANES       = 4;
  localparam int NUM_STROBES     = 4;

  // Strap load sequencer
  typedef enum logic [1:0] {
    ST_WAIT_RELEASE,
    ST_REQUEST,
    ST_RUN
  } load_state_e;

endpackage

//--- include/delay_sel_if.sv
`timescale 1ns/100ps
interface delay_sel_if #(
  parameter int N = 4
);
  logic [3:0] field   [N];
  logic [3:0] cal     [N];
  logic       use_cal [N];
  logic [3:0] code    [N];

  // Block that owns the fields and consumes the codes
  modport ctl_mp (output field, output cal, output use_cal, input code);
  // Selector that turns fields into codes
  modport sel_mp (input field, input cal, input use_cal, output code);
endinterface

//--- logic/delay_code_sel.sv
`timescale 1ns/100ps
module delay_code_sel #(
  parameter int N = 4
) (
  // Lane fields and codes
  delay_sel_if.sel_mp sel
);

  // ==========================================================================
  // Saturating add of a signed offset to a calibrated code
  function automatic logic [3:0] offset_code(input logic [3:0] cal_v, input logic [3:0] ofs_v);
    logic signed [5:0] sum;
    sum = $signed({2'b00, cal_v}) + $signed({{2{ofs_v[3]}}, ofs_v});
    if (sum < 0) begin
      offset_code = deskew_pkg::DELAY_CODE_MIN;
    end else if (sum > $signed({2'b00, deskew_pkg::DELAY_CODE_MAX})) begin
      offset_code = deskew_pkg::DELAY_CODE_MAX;
    end else begin
      offset_code = sum[3:0];
    end
  endfunction

  // ==========================================================================
  // One selector per lane
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lane
      assign sel.code[g] = sel.use_cal[g] ? offset_code(sel.cal[g], sel.field[g]) : sel.field[g];
    end
  endgenerate

endmodule

//--- logic/host_bus_deskew_delay_control.sv
`timescale 1ns/100ps
module host_bus_deskew_delay_control (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // Platform reset pin
  input  wire logic        i_platform_reset_n,
  // Configuration register port
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic        i_cfg_wr,
  input  wire logic [7:0]  i_cfg_wdata,
  input  wire logic        i_cfg_rd,
  output logic      [7:0]  o_cfg_rdata,
  // Strap ROM load handshake
  output logic             o_strap_rom_load,
  input  wire logic        i_strap_valid,
  input  wire logic [63:0] i_strap_qword,
  // Calibrated delay results
  input  wire logic [7:0]  i_cal_result_addr_hi,
  input  wire logic [7:0]  i_cal_result_data0_lo,
  // Calibration engine control
  output logic             o_auto_deskew_en,
  output logic [2:0]       o_stable_count,
  // Pad phy control
  output logic             o_pad_loopback,
  output logic [3:0]       o_addr_in_delay_sub2,
  output logic [3:0]       o_addr_in_delay_sub3,
  output logic [3:0]       o_data0_out_delay_sub0,
  output logic [3:0]       o_data0_out_delay_sub1,
  output logic [3:0]       o_strobe_out_delay [deskew_pkg::NUM_STROBES]
);

  // ==========================================================================
  // Threshold decode, used only for the engine stable count
  function automatic logic [2:0] thr_count(input logic [1:0] thr);
    case (thr)
      2'h0: begin
        thr_count = deskew_pkg::THR_ZERO_COUNT;
      end
      default: begin
        thr_count = {1'b0, thr};
      end
    endcase
  endfunction

  // Full de-skew decode, shared by the data lane selects and the strobe codes
  function automatic logic is_full_mode(input logic [1:0] mode);
    is_full_mode = mode[0] & mode[1];
  endfunction

  // ==========================================================================
  // Whole state of the block
  typedef struct packed {
    // Platform reset filter and strap sequencer
    logic [2:0]               pin_sync;
    logic                     pin_level;
    deskew_pkg::load_state_e  load_st;
    // Software visible fields
    logic [7:0]               addr_in_sub23;
    logic                     loopback;
    logic [1:0]               thr;
    logic [1:0]               mode;
    logic [7:0]               strobe_01;
    logic [7:0]               strobe_23;
    logic [7:0]               data0_sub01;
    // Read data and registered outputs
    logic [7:0]               rdata;
    logic                     loop_q;
    logic [2:0]               cnt_q;
    logic [3:0]               addr2_q;
    logic [3:0]               addr3_q;
    logic [3:0]               data0_q;
    logic [3:0]               data1_q;
    logic [15:0]              strobe_q;
  } state_s;

  state_s state_reg;
  state_s state_next;

  delay_sel_if #(.N(deskew_pkg::NUM_LANES)) sel_bus ();

  // ==========================================================================
  // Offset selector for address input and data output lanes
  delay_code_sel #(
    .N (deskew_pkg::NUM_LANES)
  ) u_sel (
    .sel (sel_bus.sel_mp)
  );

  // Lane inputs from registers and calibrated results
  // nibble pairing
  assign sel_bus.field[deskew_pkg::LANE_ADDR_SUB2]  = state_reg.addr_in_sub23[3:0];
  assign sel_bus.field[deskew_pkg::LANE_ADDR_SUB3]  = state_reg.addr_in_sub23[7:4];
  assign sel_bus.field[deskew_pkg::LANE_DATA0_SUB0] = state_reg.data0_sub01[3:0];
  assign sel_bus.field[deskew_pkg::LANE_DATA0_SUB1] = state_reg.data0_sub01[7:4];

  // Calibrated result nibbles, upper nibble to the upper lane
  assign sel_bus.cal[deskew_pkg::LANE_ADDR_SUB2]    = i_cal_result_addr_hi[3:0];
  assign sel_bus.cal[deskew_pkg::LANE_ADDR_SUB3]    = i_cal_result_addr_hi[7:4];
  assign sel_bus.cal[deskew_pkg::LANE_DATA0_SUB0]   = i_cal_result_data0_lo[3:0];
  assign sel_bus.cal[deskew_pkg::LANE_DATA0_SUB1]   = i_cal_result_data0_lo[7:4];

  // Input lanes follow calibration when mode bit 0 is set
  // input path modes
  assign sel_bus.use_cal[deskew_pkg::LANE_ADDR_SUB2]  = state_reg.mode[0];
  assign sel_bus.use_cal[deskew_pkg::LANE_ADDR_SUB3]  = state_reg.mode[0];
  assign sel_bus.use_cal[deskew_pkg::LANE_DATA0_SUB0] = is_full_mode(state_reg.mode);
  assign sel_bus.use_cal[deskew_pkg::LANE_DATA0_SUB1] = is_full_mode(state_reg.mode);

  // ==========================================================================
  // Next state
  always_comb begin
    logic       full_mode;
    logic [7:0] mode_byte;
    state_next = state_reg;
    full_mode  = is_full_mode(state_reg.mode);
    mode_byte  = {3'h0, state_reg.loopback, state_reg.thr, state_reg.mode};

    // Pin synchroniser; level changes once second and third stages agree
    // Nothing but the second stage reads the first
    state_next.pin_sync = {state_reg.pin_sync[1:0], i_platform_reset_n};
    if (state_reg.pin_sync[1] == state_reg.pin_sync[2]) begin
      state_next.pin_level = state_reg.pin_sync[2];
    end

    // Software writes, ignored while the strap load is pending
    if (i_cfg_wr && (state_reg.load_st == deskew_pkg::ST_RUN)) begin
      case (i_cfg_addr)
        deskew_pkg::OFS_ADDR_IN_SUB23: begin
          state_next.addr_in_sub23 = i_cfg_wdata;
        end
        deskew_pkg::OFS_MODE_CTL: begin
          state_next.loopback = i_cfg_wdata[deskew_pkg::LOOPBACK_BIT];
          state_next.thr      = i_cfg_wdata[deskew_pkg::THR_LSB +: 2];
          state_next.mode     = i_cfg_wdata[deskew_pkg::MODE_LSB +: 2];
        end
        deskew_pkg::OFS_STROBE_OUT_01: begin
          state_next.strobe_01 = i_cfg_wdata;
        end
        deskew_pkg::OFS_STROBE_OUT_23: begin
          state_next.strobe_23 = i_cfg_wdata;
        end
        deskew_pkg::OFS_DATA0_OUT_SUB01: begin
          state_next.data0_sub01 = i_cfg_wdata;
        end
        default: begin
          state_next.rdata = state_reg.rdata;
        end
      endcase
    end

    // Strap load sequencer
    case (state_reg.load_st)
      deskew_pkg::ST_WAIT_RELEASE: begin
        if (state_reg.pin_level) begin
          state_next.load_st = deskew_pkg::ST_REQUEST;
        end
      end
      deskew_pkg::ST_REQUEST: begin
        if (i_strap_valid) begin
          // Mode register fields
          state_next.loopback      = i_strap_qword[deskew_pkg::STRAP_LOOPBACK_BIT];
          state_next.thr           = i_strap_qword[deskew_pkg::STRAP_THR_LSB +: 2];
          state_next.mode          = i_strap_qword[deskew_pkg::STRAP_MODE_LSB +: 2];
          // One strap nibble feeds both lanes of a delay register
          state_next.addr_in_sub23 = {2{i_strap_qword[deskew_pkg::STRAP_ADDR_IN_LSB +: 4]}};
          state_next.strobe_01     = {2{i_strap_qword[deskew_pkg::STRAP_STROBE_LSB +: 4]}};
          state_next.strobe_23     = {2{i_strap_qword[deskew_pkg::STRAP_STROBE_LSB +: 4]}};
          state_next.data0_sub01   = {2{i_strap_qword[deskew_pkg::STRAP_DATA0_LSB +: 4]}};
          state_next.load_st       = deskew_pkg::ST_RUN;
        end
      end
      deskew_pkg::ST_RUN: begin
        // A new platform reset rearms the load
        if (!state_reg.pin_level) begin
          state_next.load_st = deskew_pkg::ST_WAIT_RELEASE;
        end
      end
      default: begin
        state_next.load_st = deskew_pkg::ST_WAIT_RELEASE;
      end
    endcase

    // Register readback, reserved bits read as zero
    if (i_cfg_rd) begin
      case (i_cfg_addr)
        deskew_pkg::OFS_ADDR_IN_SUB23: begin
          state_next.rdata = state_reg.addr_in_sub23;
        end
        deskew_pkg::OFS_MODE_CTL: begin
          state_next.rdata = mode_byte;
        end
        deskew_pkg::OFS_STROBE_OUT_01: begin
          state_next.rdata = state_reg.strobe_01;
        end
        deskew_pkg::OFS_STROBE_OUT_23: begin
          state_next.rdata = state_reg.strobe_23;
        end
        deskew_pkg::OFS_DATA0_OUT_SUB01: begin
          state_next.rdata = state_reg.data0_sub01;
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end

    // Registered outputs, one cycle behind fields and calibration
    // registered codes
    state_next.loop_q  = state_reg.loopback;
    state_next.cnt_q   = thr_count(state_reg.thr);
    // Address input lanes
    state_next.addr2_q = sel_bus.code[deskew_pkg::LANE_ADDR_SUB2];
    state_next.addr3_q = sel_bus.code[deskew_pkg::LANE_ADDR_SUB3];
    // Data group 0 output lanes
    state_next.data0_q = sel_bus.code[deskew_pkg::LANE_DATA0_SUB0];
    state_next.data1_q = sel_bus.code[deskew_pkg::LANE_DATA0_SUB1];
    if (full_mode) begin
      // Strobe fields are ignored in full mode
      state_next.strobe_q = {4{deskew_pkg::STROBE_FIXED_CODE}};
    end else begin
      // Manual and receive modes drive the strobe paths directly
      state_next.strobe_q = {state_reg.strobe_23, state_reg.strobe_01};
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      // Control fields and strap sequencer
      state_reg               <= '0;
      state_reg.pin_sync      <= 3'h0;
      state_reg.load_st       <= deskew_pkg::ST_WAIT_RELEASE;
      state_reg.loopback      <= deskew_pkg::LOOPBACK_RST;
      state_reg.thr           <= deskew_pkg::THR_RST;
      state_reg.mode          <= deskew_pkg::MODE_RST;
      // Delay fields
      // field reset values
      state_reg.addr_in_sub23 <= {2{deskew_pkg::DELAY_FIELD_RST}};
      state_reg.strobe_01     <= {2{deskew_pkg::DELAY_FIELD_RST}};
      state_reg.strobe_23     <= {2{deskew_pkg::DELAY_FIELD_RST}};
      state_reg.data0_sub01   <= {2{deskew_pkg::DELAY_FIELD_RST}};
      // Registered outputs until the first clocked update
      state_reg.cnt_q         <= deskew_pkg::THR_ZERO_COUNT;
      state_reg.addr2_q       <= deskew_pkg::DELAY_FIELD_RST;
      state_reg.addr3_q       <= deskew_pkg::DELAY_FIELD_RST;
      state_reg.data0_q       <= deskew_pkg::DELAY_FIELD_RST;
      state_reg.data1_q       <= deskew_pkg::DELAY_FIELD_RST;
      state_reg.strobe_q      <= {4{deskew_pkg::STROBE_FIXED_CODE}};
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  // Register port and strap request
  assign o_cfg_rdata            = state_reg.rdata;
  assign o_strap_rom_load       = (state_reg.load_st == deskew_pkg::ST_REQUEST);

  // Calibration engine controls
  assign o_auto_deskew_en       = state_reg.mode[0];
  assign o_stable_count         = state_reg.cnt_q;

  // Pad controls and delay codes
  assign o_pad_loopback         = state_reg.loop_q;
  assign o_addr_in_delay_sub2   = state_reg.addr2_q;
  assign o_addr_in_delay_sub3   = state_reg.addr3_q;
  assign o_data0_out_delay_sub0 = state_reg.data0_q;
  assign o_data0_out_delay_sub1 = state_reg.data1_q;

  // Strobe n takes nibble n: even strobes lower, odd strobes upper
  genvar s;
  generate
    for (s = 0; s < deskew_pkg::NUM_STROBES; s++) begin : g_strobe
      assign o_strobe_out_delay[s] = state_reg.strobe_q[4*s +: 4];
    end
  endgenerate

endmodule

//--- tb/strap_rom_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Strap ROM source answering the quadword load request
module strap_rom_model #(
  parameter int          LAT   = 2,
  parameter logic [63:0] QWORD = 64'h0000_0000_0000_0000
) (
  // Clock
  input  wire logic        i_clk_sys,
  // Load handshake
  input  wire logic        i_load_req,
  output logic             o_valid,
  output logic [63:0]      o_qword
);
  int wait_cnt;
  // Idle values before the first request
  initial begin
    o_valid = 1'b0;
    o_qword = ~QWORD;
    wait_cnt = 0;
  end
  // Answer after LAT cycles; off-cycle data is inverted so stale bits never pass
  // strap quadword delivery
  always @(negedge i_clk_sys) begin
    if (!i_load_req || o_valid) begin
      o_valid <= 1'b0;
      o_qword <= ~QWORD;
      wait_cnt <= 0;
    end else if (wait_cnt == LAT) begin
      o_valid <= 1'b1;
      o_qword <= QWORD;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

//--- tb/deskew_ctl_properties.sv
`timescale 1ns/100ps
// ==========================================================================
// Port checks of the deskew control block
module deskew_ctl_properties (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_reset_n,
  // Register port and strap load
  input wire logic [7:0]  i_cfg_addr,
  input wire logic        i_cfg_wr,
  input wire logic [7:0]  i_cfg_wdata,
  input wire logic        i_cfg_rd,
  input wire logic [7:0]  o_cfg_rdata,
  input wire logic        o_strap_rom_load,
  input wire logic        i_strap_valid,
  input wire logic [63:0] i_strap_qword,
  // Engine and pad controls
  input wire logic        o_auto_deskew_en,
  input wire logic [2:0]  o_stable_count,
  input wire logic        o_pad_loopback,
  input wire logic [3:0]  o_strobe_out_delay [deskew_pkg::NUM_STROBES]
);
  typedef struct packed {
    logic       done;
    logic       lb;
    logic [1:0] thr;
    logic [1:0] mode;
  } shadow_s;
  shadow_s sh_reg;
  shadow_s sh_next;
  // Shadow of the mode register; writes count only once the strap load is done
  always_comb begin
    sh_next = sh_reg;
    if (o_strap_rom_load && i_strap_valid) begin
      sh_next = {1'b1, i_strap_qword[56], i_strap_qword[7:4]};
    end else if (sh_reg.done && i_cfg_wr && i_cfg_addr == 8'ha9) begin
      sh_next = {1'b1, i_cfg_wdata[4:0]};
    end
  end
  // Shadow register with reset values
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sh_reg <= {1'b0, 1'b0, 2'h1, 2'h3};
    end else begin
      sh_reg <= sh_next;
    end
  end
  // Detections per step for each threshold code
  function automatic logic [2:0] thr_count(input logic [1:0] t);
    return (t == 2'h1) ? 3'h1 : ((t == 2'h2) ? 3'h2 : 3'h3);
  endfunction
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // ==========================================================================
  // Assertions
  strap_drop_a: assert property (o_strap_rom_load && i_strap_valid |=> !o_strap_rom_load)
    else $error("strap request stayed high after load");
  strap_hold_a: assert property (o_strap_rom_load && !i_strap_valid |=> o_strap_rom_load)
    else $error("strap request dropped without valid");
  mode_read_a: assert property (i_cfg_rd && i_cfg_addr == 8'ha9 |=> o_cfg_rdata == {3'h0, $past(sh_reg[4:0])})
    else $error("mode register readback wrong");
  unmapped_read_a: assert property (i_cfg_rd && (i_cfg_addr < 8'ha8 || i_cfg_addr > 8'hac) |=> o_cfg_rdata == 8'h00)
    else $error("unmapped read not zero");
  auto_en_a: assert property ($past(i_reset_n) && $stable(sh_reg.mode) |-> o_auto_deskew_en == sh_reg.mode[0])
    else $error("auto deskew enable does not follow mode");
  loopback_a: assert property ($past(i_reset_n) && $stable(sh_reg.lb) |-> o_pad_loopback == sh_reg.lb)
    else $error("pad loopback does not follow its bit");
  stable_cnt_a: assert property ($past(i_reset_n) && $stable(sh_reg.thr) |-> o_stable_count == thr_count(sh_reg.thr))
    else $error("stable count does not match threshold");
  strobe_fixed_a: assert property ($past(i_reset_n) && $stable(sh_reg.mode) && sh_reg.mode == 2'h3 |->
    o_strobe_out_delay[0] == 4'h4 && o_strobe_out_delay[1] == 4'h4 &&
    o_strobe_out_delay[2] == 4'h4 && o_strobe_out_delay[3] == 4'h4)
    else $error("strobe codes not fixed in full mode");
  // Main scenarios reached
  strap_seen_c: cover property (o_strap_rom_load && i_strap_valid);
  rx_mode_c: cover property (sh_reg.mode == 2'h1 && o_auto_deskew_en);
  unmapped_c: cover property (i_cfg_rd && i_cfg_addr > 8'hac);
endmodule

bind host_bus_deskew_delay_control deskew_ctl_properties u_props (.*);

//--- tb/host_bus_deskew_delay_control_tb_top.sv
`timescale 1ns/100ps
// ==========================================================================
// Self-checking bench of the deskew control block
module host_bus_deskew_delay_control_tb_top;
  logic        clk, rst_n, plat_n, wr, rd, load, valid, auto_en, loopback;
  logic [7:0]  addr, wdata, rdata, cal_a, cal_d;
  logic [63:0] qword;
  logic [2:0]  stable;
  logic [3:0]  a2, a3, d0, d1;
  logic [3:0]  strobe [deskew_pkg::NUM_STROBES];
  int          fail_count, checks_done;
  // ==========================================================================
  // Block, strap source and clock
  host_bus_deskew_delay_control u_dut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_platform_reset_n(plat_n),
    .i_cfg_addr(addr), .i_cfg_wr(wr), .i_cfg_wdata(wdata), .i_cfg_rd(rd), .o_cfg_rdata(rdata),
    .o_strap_rom_load(load), .i_strap_valid(valid), .i_strap_qword(qword),
    .i_cal_result_addr_hi(cal_a), .i_cal_result_data0_lo(cal_d),
    .o_auto_deskew_en(auto_en), .o_stable_count(stable), .o_pad_loopback(loopback),
    .o_addr_in_delay_sub2(a2), .o_addr_in_delay_sub3(a3),
    .o_data0_out_delay_sub0(d0), .o_data0_out_delay_sub1(d1), .o_strobe_out_delay(strobe));
  strap_rom_model #(.LAT(2), .QWORD(64'h010c_0900_5000_000f)) u_rom (
    .i_clk_sys(clk), .i_load_req(load), .o_valid(valid), .o_qword(qword));
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================================
  // Compare, register access and code check
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({36'h0, rdata}, {36'h0, e});
  endtask
  // Codes: sub2, sub3, data 0, data 1, strobes 0 to 3; then loopback, count, auto
  task automatic codes_chk(input logic [31:0] e, input logic [11:0] c);
    repeat (2) @(negedge clk);
    chk({a2, a3, d0, d1, strobe[0], strobe[1], strobe[2], strobe[3], 3'h0, loopback, 1'b0, stable, 3'h0, auto_en},
        {e, c});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'ha8 + 8'(i), (i == 1) ? 8'h07 : 8'h77);
    end
    rd_chk(8'had, 8'h00);
    wr_reg(8'ha8, 8'h12);
    rd_chk(8'ha8, 8'h77);
    codes_chk(32'h7777_4444, 12'h011);
    chk({43'h0, load}, 44'h0);
  endtask
  task automatic t_strap;
    logic [39:0] e;
    e = 40'h55_1099_99cc;
    plat_n = 1'b1;
    for (int n = 0; n < 20 && load !== 1'b1; n++) begin
      @(negedge clk);
    end
    chk({43'h0, load}, 44'h1);
    for (int n = 0; n < 20 && load !== 1'b0; n++) begin
      @(negedge clk);
    end
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'ha8 + 8'(i), e[39 - 8 * i -: 8]);
    end
    codes_chk(32'h55cc_9999, 12'h130);
  endtask
  task automatic t_rx;
    cal_a = 8'he3;
    cal_d = 8'h52;
    wr_reg(8'ha9, 8'h01);
    wr_reg(8'ha8, 8'h78);
    wr_reg(8'hac, 8'h3f);
    wr_reg(8'haa, 8'h21);
    wr_reg(8'hab, 8'h43);
    codes_chk(32'h0ff3_1234, 12'h031);
  endtask
  task automatic t_full;
    wr_reg(8'ha9, 8'h0b);
    wr_reg(8'hac, 8'hf1);
    wr_reg(8'ha8, 8'h92);
    codes_chk(32'h5734_4444, 12'h021);
    cal_d = 8'h0e;
    #1 chk({40'h0, d0}, 44'h3);
    codes_chk(32'h57f0_4444, 12'h021);
    wr_reg(8'ha9, 8'he6);
    rd_chk(8'ha9, 8'h06);
    codes_chk(32'h291f_1234, 12'h010);
  endtask
  // A second platform reset rearms the strap load and reloads every field
  task automatic t_replat;
    plat_n = 1'b0;
    repeat (8) @(negedge clk);
    chk({43'h0, load}, 44'h0);
    plat_n = 1'b1;
    for (int n = 0; n < 20 && load !== 1'b1; n++) begin
      @(negedge clk);
    end
    chk({43'h0, load}, 44'h1);
    for (int n = 0; n < 20 && load !== 1'b0; n++) begin
      @(negedge clk);
    end
    rd_chk(8'ha8, 8'h55);
    rd_chk(8'ha9, 8'h10);
    codes_chk(32'h55cc_9999, 12'h130);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    plat_n = 1'b0;
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
    cal_a = 8'h00;
    cal_d = 8'h00;
    fail_count = 0;
    checks_done = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_strap();
    t_rx();
    t_full();
    t_replat();
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule
